// [shb_pkg.sv]
// Contract
// RL1 - Host opens a shared-bus session with one wake token reaching every chip.
// RL2 - Pause command keeps only the chip whose selector equals its parameter awake.
// RL3 - Idle flag sends the one active chip idle; idle chips disregard it.
// RL4 - Host should finally wake all chips, then put them all to sleep.
// RL5 - Policy byte zero: selector updates always succeed, without any limit.
// RL6 - Nonzero policy, zero selector at lock: one nonzero selector write accepted.
// RL7 - Data-zone lock state never affects the selector update outcome.
// RL8 - Nonzero policy and selector after lock: every update refused, value kept.
// RL9 - Multi-byte arrays travel in index order, element zero first.
// RL10 - Two-byte parameters travel low-order byte first, then high-order byte.
// RL11 - Single-wire variant serializes every byte least significant bit first.
// RL12 - I2C variant serializes every byte most significant bit first.
// RL13 - Single-wire traffic stays at or below twenty-six kilobits per second.
// RL14 - I2C traffic stays at or below one megabit per second.
// RL15 - Interface variant fixed by the part; bytes above the link identical.
// RL16 - Failsafe watchdog forces low-power sleep on expiry, whatever is running.
// RL17 - An idle chip stays idle until the next wake token; idle flag is BB.
// RL18 - Idle or sleeping chips ignore all data tokens until a legal wake.
// RL19 - One-time policy: after a nonzero write, further updates error, value kept.
package shb_pkg;

  // ----------------------------------------------------------------
  // Flag bytes and command encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG_CMD   = 8'h77;
  localparam logic [7:0] FLAG_XMIT  = 8'h88;
  localparam logic [7:0] FLAG_IDLE  = 8'hBB;
  localparam logic [7:0] FLAG_SLEEP = 8'hCC;
  localparam logic [7:0] OP_PAUSE   = 8'h01;
  localparam logic [7:0] OP_UPDATE  = 8'h20;
  localparam logic [7:0] STAT_OK    = 8'h00;
  localparam logic [7:0] STAT_ERR   = 8'h0F;
  localparam logic [7:0] SEL_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Command frame layout: opcode, param1, second_command_parameter low, second_command_parameter high
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_OPCODE = 2'h0;
  localparam logic [1:0] IDX_PARAM1 = 2'h1;
  localparam logic [1:0] IDX_P2_LO  = 2'h2;
  localparam logic [1:0] IDX_P2_HI  = 2'h3;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ        = 125000;
  localparam int CLK_MHZ        = 125;
  localparam int SW_MAX_KBPS    = 26;
  localparam int I2C_MAX_KBPS   = 1000;
  localparam int SW_MIN_BIT_CYC = (CLK_KHZ + SW_MAX_KBPS - 1) / SW_MAX_KBPS;
  localparam int I2C_MIN_BIT_CYC = (CLK_KHZ + I2C_MAX_KBPS - 1) / I2C_MAX_KBPS;
  localparam int WDOG_TIME_US   = 1000;
  localparam int WDOG_CYC       = WDOG_TIME_US * CLK_MHZ;
  // Strap is latched once both synchroniser stages hold the pin level
  localparam logic [1:0] STRAP_LATCH_CNT = 2'h2;
  localparam logic [1:0] STRAP_DONE_CNT  = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_SLEEP, ST_IDLE, ST_AWAKE} shb_state_type;

  typedef struct packed {
    logic       cfg_locked;
    logic [7:0] select_update_policy;
    logic [7:0] data_zone_lock_state;
  } shb_cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } shb_resp_type;

endpackage

// [shb_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module shb_timer
  import shb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [31:0] load,
  // Status
  output logic             busy,
  output logic             done
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt_ff;
  logic        done_ff;
  logic        nxt_done_ff;

  // ----------------------------------------------------------------
  // Down counter; start wins over stop so a restart is never lost
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cnt_ff  = cnt_ff;
    nxt_done_ff = 1'b0;
    if (start) begin
      nxt_cnt_ff = load;
    end else if (stop) begin
      nxt_cnt_ff = 32'h0000_0000;
    end else if (cnt_ff != 32'h0000_0000) begin
      nxt_cnt_ff  = cnt_ff - 32'h0000_0001;
      nxt_done_ff = (cnt_ff == 32'h0000_0001);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_ff  <= 32'h0000_0000;
      done_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt_ff;
      done_ff <= nxt_done_ff;
    end
  end

  assign busy = (cnt_ff != 32'h0000_0000);
  assign done = done_ff;

endmodule
`default_nettype wire

// [shb_selector.sv]
`timescale 1ns/1ps
`default_nettype none
module shb_selector
  import shb_pkg::*;
#(
  parameter int SW_BIT_CYC = SW_MIN_BIT_CYC,
  parameter int WDOG_CYCLES = WDOG_CYC
) (
  // Clock, reset, enable
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // Part strap: high for the I2C variant
  input  wire logic         iface_i2c_pin,
  // Link receive tokens
  input  wire logic         wake_tok,
  input  wire logic         rx_bit_valid,
  input  wire logic         rx_bit,
  // Link transmit bits
  input  wire logic         tx_take,
  output logic              tx_bit,
  output logic              tx_pending,
  // Configuration
  input  wire shb_cfg_type  cfg,
  input  wire logic [7:0]   selector_init,
  // Status
  output logic              chip_awake,
  output logic              chip_idle,
  output logic              chip_asleep,
  output logic [7:0]        selector,
  output shb_resp_type      resp,
  output logic              rate_err
);

  // ----------------------------------------------------------------
  // Bit position within a byte for the fixed variant
  // ----------------------------------------------------------------
  function automatic logic [2:0] bit_pos(input logic i2c, input logic [2:0] n);
    bit_pos = i2c ? (BIT_LAST - n) : n;
  endfunction

  // ----------------------------------------------------------------
  // Strap synchroniser, captured once after reset release
  // ----------------------------------------------------------------
  logic       sync1_ff, sync2_ff, i2c_ff;
  logic       nxt_i2c_ff;
  logic [1:0] strap_cnt_ff, nxt_strap_cnt_ff;

  // Latch late enough that the reset value of the stages is never taken
  always_comb begin
    nxt_i2c_ff       = i2c_ff;
    nxt_strap_cnt_ff = strap_cnt_ff;
    if (strap_cnt_ff == STRAP_LATCH_CNT) begin
      nxt_i2c_ff = sync2_ff; // RL15
    end
    if (strap_cnt_ff != STRAP_DONE_CNT) begin
      nxt_strap_cnt_ff = 2'(strap_cnt_ff + 2'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_ff      <= 1'b0;
      sync2_ff      <= 1'b0;
      i2c_ff        <= 1'b0;
      strap_cnt_ff  <= 2'h0;
    end else if (ce) begin
      sync1_ff      <= iface_i2c_pin;
      sync2_ff      <= sync1_ff;
      i2c_ff        <= nxt_i2c_ff;
      strap_cnt_ff  <= nxt_strap_cnt_ff;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  shb_state_type state_ff, nxt_state_ff;
  logic [7:0]    shift_ff, nxt_shift_ff;
  logic [2:0]    bitcnt_ff, nxt_bitcnt_ff;
  logic          frame_ff, nxt_frame_ff;
  logic [1:0]    idx_ff, nxt_idx_ff;
  logic [7:0]    op_ff, nxt_op_ff;
  logic [7:0]    p1_ff, nxt_p1_ff;
  logic [7:0]    p2lo_ff, nxt_p2lo_ff;
  logic [7:0]    sel_ff, nxt_sel_ff;
  logic          sel_loaded_ff;
  logic [7:0]    txbyte_ff, nxt_txbyte_ff;
  logic          have_resp_ff, nxt_have_resp_ff;
  logic          txpend_ff, nxt_txpend_ff;
  logic [2:0]    txcnt_ff, nxt_txcnt_ff;
  logic          txbit_ff, nxt_txbit_ff;
  shb_resp_type  resp_ff, nxt_resp_ff;
  logic          rate_err_ff, nxt_rate_err_ff;

  // ----------------------------------------------------------------
  // Timers: bit-rate guard and failsafe watchdog
  // ----------------------------------------------------------------
  logic        rate_busy, wd_done, wd_start, wd_stop;
  logic        bit_acc;
  logic [31:0] rate_load;

  assign rate_load = i2c_ff ? 32'(I2C_MIN_BIT_CYC) : 32'(SW_BIT_CYC); // RL13 RL14

  shb_timer u_rate (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (bit_acc),
    .stop    (1'b0),
    .load    (rate_load),
    .busy    (rate_busy),
    .done    ()
  );

  shb_timer u_wdog (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (wd_start),
    .stop    (wd_stop),
    .load    (32'(WDOG_CYCLES)),
    .busy    (),
    .done    (wd_done)
  );

  // ----------------------------------------------------------------
  // Receive decode; bits arriving faster than the rate are dropped
  // ----------------------------------------------------------------
  logic       live, byte_done, exec_cmd, upd_ok;
  logic [7:0] rx_byte;

  assign live      = (state_ff == ST_AWAKE) && !wd_done && !wake_tok; // RL18
  assign bit_acc   = live && rx_bit_valid && !rate_busy;
  assign byte_done = bit_acc && (bitcnt_ff == BIT_LAST);
  assign exec_cmd  = byte_done && frame_ff && (idx_ff == IDX_P2_HI);
  // Lock state byte deliberately plays no part here
  assign upd_ok    = (cfg.select_update_policy == 8'h00) || !cfg.cfg_locked ||
                     ((sel_ff == 8'h00) && (p2lo_ff != 8'h00)); // RL5 RL6 RL7 RL8 RL19

  always_comb begin
    rx_byte = shift_ff;
    rx_byte[bit_pos(i2c_ff, bitcnt_ff)] = rx_bit; // RL11 RL12
  end

  // ----------------------------------------------------------------
  // Next-state logic for the session, frame and response
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state_ff     = state_ff;
    nxt_shift_ff     = shift_ff;
    nxt_bitcnt_ff    = bitcnt_ff;
    nxt_frame_ff     = frame_ff;
    nxt_idx_ff       = idx_ff;
    nxt_op_ff        = op_ff;
    nxt_p1_ff        = p1_ff;
    nxt_p2lo_ff      = p2lo_ff;
    nxt_sel_ff       = sel_loaded_ff ? sel_ff : selector_init;
    nxt_txbyte_ff    = txbyte_ff;
    nxt_have_resp_ff = have_resp_ff;
    nxt_txpend_ff    = txpend_ff;
    nxt_txcnt_ff     = txcnt_ff;
    nxt_txbit_ff     = txbit_ff;
    nxt_resp_ff      = '{valid: 1'b0, code: resp_ff.code};
    nxt_rate_err_ff  = live && rx_bit_valid && rate_busy;
    wd_start         = 1'b0;
    wd_stop          = 1'b0;
    case (state_ff)
      ST_SLEEP, ST_IDLE: begin
        // Data tokens fall on the floor until a wake
        if (wake_tok) begin // RL17 RL18
          nxt_state_ff  = ST_AWAKE;
          nxt_bitcnt_ff = 3'h0;
          nxt_frame_ff  = 1'b0;
          nxt_txpend_ff = 1'b0;
          wd_start      = 1'b1;
        end
      end
      ST_AWAKE: begin
        if (wd_done) begin
          nxt_state_ff = ST_SLEEP; // RL16
          nxt_txpend_ff = 1'b0;
        end else if (bit_acc) begin
          nxt_shift_ff  = rx_byte;
          nxt_bitcnt_ff = 3'(bitcnt_ff + 3'h1);
        end
        if (byte_done && !frame_ff) begin
          case (rx_byte)
            FLAG_CMD: begin
              nxt_frame_ff = 1'b1;
              nxt_idx_ff   = IDX_OPCODE;
            end
            FLAG_IDLE: begin
              nxt_state_ff = ST_IDLE; // RL3
              wd_stop      = 1'b1;
            end
            FLAG_SLEEP: begin
              nxt_state_ff = ST_SLEEP;
              wd_stop      = 1'b1;
            end
            FLAG_XMIT: begin
              nxt_txpend_ff = have_resp_ff;
              nxt_txcnt_ff  = 3'h0;
              nxt_txbit_ff  = txbyte_ff[bit_pos(i2c_ff, 3'h0)]; // RL11 RL12
            end
            default: begin
              nxt_frame_ff = 1'b0;
            end
          endcase
        end else if (byte_done) begin
          // Frame bytes land in index order
          nxt_idx_ff = 2'(idx_ff + 2'h1); // RL9
          case (idx_ff)
            IDX_OPCODE: nxt_op_ff   = rx_byte;
            IDX_PARAM1: nxt_p1_ff   = rx_byte;
            IDX_P2_LO:  nxt_p2lo_ff = rx_byte; // RL10
            default:    nxt_frame_ff = 1'b0;
          endcase
        end
        if (exec_cmd) begin
          nxt_have_resp_ff = 1'b1;
          nxt_resp_ff.valid = 1'b1;
          nxt_resp_ff.code  = STAT_ERR;
          if (op_ff == OP_PAUSE) begin
            nxt_resp_ff.code = STAT_OK;
            if (p1_ff != sel_ff) begin
              nxt_state_ff      = ST_IDLE; // RL2
              nxt_resp_ff.valid = 1'b0;
              nxt_have_resp_ff  = 1'b0;
              wd_stop           = 1'b1;
            end
          end else if ((op_ff == OP_UPDATE) && upd_ok) begin
            nxt_sel_ff       = p2lo_ff; // RL5 RL6
            nxt_resp_ff.code = STAT_OK;
          end
          nxt_txbyte_ff = nxt_resp_ff.code;
        end
        if (tx_take && txpend_ff) begin
          nxt_txcnt_ff  = 3'(txcnt_ff + 3'h1);
          nxt_txpend_ff = (txcnt_ff != BIT_LAST);
          nxt_txbit_ff  = txbyte_ff[bit_pos(i2c_ff, 3'(txcnt_ff + 3'h1))]; // RL11 RL12
        end
      end
      default: begin
        nxt_state_ff = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff      <= ST_SLEEP;
      shift_ff      <= 8'h00;
      bitcnt_ff     <= 3'h0;
      frame_ff      <= 1'b0;
      idx_ff        <= 2'h0;
      op_ff         <= 8'h00;
      p1_ff         <= 8'h00;
      p2lo_ff       <= 8'h00;
      sel_ff        <= SEL_RESET;
      sel_loaded_ff <= 1'b0;
      txbyte_ff     <= 8'h00;
      have_resp_ff  <= 1'b0;
      txpend_ff     <= 1'b0;
      txcnt_ff      <= 3'h0;
      txbit_ff      <= 1'b0;
      resp_ff       <= '0;
      rate_err_ff   <= 1'b0;
    end else if (ce) begin
      state_ff      <= nxt_state_ff;
      shift_ff      <= nxt_shift_ff;
      bitcnt_ff     <= nxt_bitcnt_ff;
      frame_ff      <= nxt_frame_ff;
      idx_ff        <= nxt_idx_ff;
      op_ff         <= nxt_op_ff;
      p1_ff         <= nxt_p1_ff;
      p2lo_ff       <= nxt_p2lo_ff;
      sel_ff        <= nxt_sel_ff;
      sel_loaded_ff <= 1'b1;
      txbyte_ff     <= nxt_txbyte_ff;
      have_resp_ff  <= nxt_have_resp_ff;
      txpend_ff     <= nxt_txpend_ff;
      txcnt_ff      <= nxt_txcnt_ff;
      txbit_ff      <= nxt_txbit_ff;
      resp_ff       <= nxt_resp_ff;
      rate_err_ff   <= nxt_rate_err_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign chip_awake  = (state_ff == ST_AWAKE);
  assign chip_idle   = (state_ff == ST_IDLE);
  assign chip_asleep = (state_ff == ST_SLEEP);
  assign selector    = sel_ff;
  assign resp        = resp_ff;
  assign rate_err    = rate_err_ff;
  assign tx_bit      = txbit_ff;
  assign tx_pending  = txpend_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_idle_flag_enter: assert property (ce && byte_done && !frame_ff && rx_byte == FLAG_IDLE |=> chip_idle) // RL3
    else $error("idle flag did not idle the chip");
  a_idle_holds_wake: assert property (ce && chip_idle && !wake_tok |=> chip_idle && $stable(sel_ff)) // RL17
    else $error("idle chip left idle without wake");
  a_sleep_ignores_bits: assert property (ce && !chip_awake && rx_bit_valid && !wake_tok |=> !chip_awake && !resp.valid) // RL18
    else $error("sleeping chip reacted to data");
  a_pause_mismatch_idle: assert property (ce && exec_cmd && op_ff == OP_PAUSE && p1_ff != sel_ff |=> chip_idle) // RL2
    else $error("mismatching chip stayed awake");
  a_unlimited_update: assert property (ce && exec_cmd && op_ff == OP_UPDATE && cfg.select_update_policy == 8'h00
                                       |=> selector == $past(p2lo_ff) && resp.code == STAT_OK) // RL5
    else $error("unlimited update failed");
  a_onetime_update: assert property (ce && exec_cmd && op_ff == OP_UPDATE && cfg.select_update_policy != 8'h00
                                     && cfg.cfg_locked && sel_ff == 8'h00 && p2lo_ff != 8'h00
                                     |=> selector == $past(p2lo_ff)) // RL6
    else $error("one-time update not taken");
  a_fixed_refused: assert property (ce && exec_cmd && op_ff == OP_UPDATE && cfg.select_update_policy != 8'h00
                                    && cfg.cfg_locked && sel_ff != 8'h00
                                    |=> resp.valid && resp.code == STAT_ERR && $stable(selector)) // RL8 RL19
    else $error("fixed selector was changed");
  a_wdog_to_sleep: assert property (ce && chip_awake && wd_done |=> chip_asleep) // RL16
    else $error("watchdog expiry did not sleep");
  a_rate_guard: assert property (ce && live && rx_bit_valid && rate_busy |=> rate_err && $stable(bitcnt_ff)) // RL13 RL14
    else $error("overspeed bit accepted");

endmodule
`default_nettype wire

// [shb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module shb_host_model
  import shb_pkg::*;
(
  // Clock
  input  wire logic ref_clk,
  // Tokens towards the chip
  output logic      wake_tok,
  output logic      rx_bit_valid,
  output logic      rx_bit,
  output logic      tx_take,
  // Response bits from the chip
  input  wire logic tx_bit,
  input  wire logic tx_pending
);
  // ----------------------------------------------------------------
  // Link settings, set by the bench per variant
  // ----------------------------------------------------------------
  logic msb_first = 1'b0;
  int   gap       = 12;
  int   stall     = 0;

  initial begin
    wake_tok     = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit       = 1'b0;
    tx_take      = 1'b0;
  end

  // One wake token reaches every chip on the line
  task automatic wake();
    @(posedge ref_clk);
    wake_tok <= 1'b1;
    @(posedge ref_clk);
    wake_tok <= 1'b0;
  endtask

  // Released data line shows the inverse, never a stale level
  task automatic send_bit(input logic b);
    @(posedge ref_clk);
    rx_bit_valid <= 1'b1;
    rx_bit       <= b;
    @(posedge ref_clk);
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~b;
    repeat (gap) @(posedge ref_clk);
  endtask

  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      send_bit(msb_first ? v[7-i] : v[i]);
    end
  endtask

  // Command block in index order, parameter two low byte first
  task automatic send_frame(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2);
    send_byte(FLAG_CMD);
    send_byte(op);
    send_byte(p1);
    send_byte(p2[7:0]);
    send_byte(p2[15:8]);
  endtask

  // Sampled at the falling edge, so the chip's update has landed
  task automatic recv_byte(output logic [7:0] v, output logic ok);
    int n;
    v  = 8'h00;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      @(negedge ref_clk);
      while (tx_pending !== 1'b1 && n < 50) begin
        @(negedge ref_clk);
        n++;
      end
      if (tx_pending !== 1'b1) ok = 1'b0;
      v[msb_first ? 7-i : i] = tx_bit;
      @(posedge ref_clk);
      tx_take <= 1'b1;
      @(posedge ref_clk);
      tx_take <= 1'b0;
      repeat (stall) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// [shb_selector_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module shb_selector_tb
  import shb_pkg::*;
;
  localparam int BITC = 8;
  localparam int WDOG = 10000;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic         ref_clk       = 1'b0;
  logic         reset_n       = 1'b0;
  logic         iface_i2c_pin = 1'b0;
  logic         ce            = 1'b1;
  shb_cfg_type  cfg           = '0;
  logic [7:0]   selector_init = 8'h00;
  logic         wake_tok, rx_bit_valid, rx_bit, tx_take, tx_bit, tx_pending;
  logic         chip_awake, chip_idle, chip_asleep, rate_err;
  logic [7:0]   selector;
  shb_resp_type resp;
  int           err_count       = 0;
  int           samples_checked = 0;
  int           n_resp          = 0;
  int           n_rerr          = 0;

  always #4 ref_clk = ~ref_clk;

  shb_selector #(.SW_BIT_CYC(BITC), .WDOG_CYCLES(WDOG)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .iface_i2c_pin(iface_i2c_pin),
    .wake_tok(wake_tok), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_take(tx_take),
    .tx_bit(tx_bit), .tx_pending(tx_pending), .cfg(cfg), .selector_init(selector_init),
    .chip_awake(chip_awake), .chip_idle(chip_idle), .chip_asleep(chip_asleep),
    .selector(selector), .resp(resp), .rate_err(rate_err));

  shb_host_model host (
    .ref_clk(ref_clk), .wake_tok(wake_tok), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .tx_take(tx_take), .tx_bit(tx_bit), .tx_pending(tx_pending));

  // Pulses are counted, since they are gone before a task returns
  always @(posedge ref_clk) begin
    if (resp.valid === 1'b1) n_resp++;
    if (rate_err === 1'b1) n_rerr++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // State as {awake, idle, asleep}, read where settled
  task automatic chk_st(input logic [7:0] exp);
    @(negedge ref_clk);
    chk({5'h00, chip_awake, chip_idle, chip_asleep}, exp);
    @(posedge ref_clk);
  endtask

  // Strap must be steady before the edge that latches it
  task automatic do_reset(input logic strap);
    iface_i2c_pin <= strap;
    reset_n       <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n       <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host.msb_first = strap;
    host.gap       = strap ? 135 : 12;
    host.stall     = $urandom % 4;
  endtask

  // Command, then turn the bus round and read the status byte
  task automatic run_cmd(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2,
                         input logic [7:0] exp_code);
    int         n0;
    logic [7:0] rb;
    logic       ok;
    n0 = n_resp;
    host.send_frame(op, p1, p2);
    @(negedge ref_clk);
    chk(resp.code, exp_code);
    chk(8'(n_resp - n0), 8'h01);
    host.send_byte(FLAG_XMIT);
    host.recv_byte(rb, ok);
    chk(rb, exp_code);
    chk({7'h00, ok}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] sel_m, nv, code_m;
    logic [7:0] pol_t [4];
    logic       lck_t [4];
    logic [7:0] ini_t [4];
    void'($urandom(32'h68dfbbb7));
    // Sharing: pause keeps only the matching chip awake
    sel_m = 8'h01 + 8'($urandom % 200);
    cfg           <= '{1'b1, 8'h00, 8'($urandom)};
    selector_init <= sel_m;
    do_reset(1'b0);
    chk_st(8'h01);
    chk(selector, sel_m);
    host.send_byte(FLAG_IDLE);
    chk_st(8'h01);
    host.wake();
    chk_st(8'h04);
    run_cmd(OP_PAUSE, sel_m, 16'($urandom), STAT_OK);
    chk_st(8'h04);
    host.send_frame(OP_PAUSE, sel_m ^ 8'h5A, 16'h0000);
    chk_st(8'h02);
    host.send_byte(FLAG_SLEEP);
    chk_st(8'h02);
    host.wake();
    chk_st(8'h04);
    host.send_byte(FLAG_IDLE);
    chk_st(8'h02);
    host.send_byte(FLAG_IDLE);
    chk_st(8'h02);
    // Update policies: unlimited, one-time, fixed, unlocked
    pol_t = '{8'h00, 8'h5A, 8'h5A, 8'h5A};
    lck_t = '{1'b1, 1'b1, 1'b1, 1'b0};
    ini_t = '{8'($urandom), 8'h00, 8'h09, 8'h09};
    for (int c = 0; c < 4; c++) begin
      sel_m = ini_t[c];
      selector_init <= sel_m;
      cfg           <= '{lck_t[c], pol_t[c], 8'($urandom)};
      do_reset(1'b0);
      host.wake();
      for (int k = 0; k < 2; k++) begin
        nv     = 8'h01 + 8'($urandom % 254);
        code_m = STAT_ERR;
        if (pol_t[c] == 8'h00 || !lck_t[c] || sel_m == 8'h00) begin
          sel_m  = nv;
          code_m = STAT_OK;
        end
        cfg.data_zone_lock_state <= 8'($urandom);
        run_cmd(OP_UPDATE, 8'($urandom), {8'($urandom), nv}, code_m);
        chk(selector, sel_m);
      end
    end
    // Rate guard, then the watchdog during a stalled byte
    do_reset(1'b0);
    host.wake();
    host.gap = 0;
    host.send_bit(1'b1);
    host.send_bit(1'b1);
    host.gap = 12;
    repeat (2) @(posedge ref_clk);
    chk(8'(n_rerr), 8'h01);
    repeat (WDOG - 60) @(posedge ref_clk);
    chk_st(8'h04);
    repeat (80) @(posedge ref_clk);
    chk_st(8'h01);
    // Two-wire variant: most significant bit first
    do_reset(1'b1);
    host.wake();
    host.send_byte(FLAG_IDLE);
    chk_st(8'h02);
    // Enable low: a wake token must not move a frozen chip
    ce <= 1'b0;
    host.wake();
    chk_st(8'h02);
    ce <= 1'b1;
    // Wind-down: wake everything, then put it to sleep
    host.wake();
    chk_st(8'h04);
    // Unknown opcode: error byte is not symmetric, so bit order shows
    run_cmd(8'h3C, 8'h00, 16'h0000, STAT_ERR);
    host.send_byte(FLAG_SLEEP);
    chk_st(8'h01);
    give_verdict();
  end

  // Hang guard, well above the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
